// File: rtl/bcd_pkg.sv
// Shared constants for the cascadable decimal up/down counter digit.
package bcd_pkg;
    localparam int unsigned  SYS_CLK_HZ      = 20_000_000;
    localparam int unsigned  CNT_CLK_MAX_HZ  = 5_000_000;
    localparam int unsigned  DIR_SETUP_NS    = 50;
    localparam int unsigned  SYS_CLK_NS      = 1_000_000_000 / SYS_CLK_HZ;
    // Least times round up to whole system clock cycles.
    localparam int unsigned  DIR_SETUP_CYC   = (DIR_SETUP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int unsigned  CNT_PERIOD_CYC  = (SYS_CLK_HZ + CNT_CLK_MAX_HZ - 1) / CNT_CLK_MAX_HZ;

    localparam logic [3:0]   DIGIT_MIN       = 4'h0;
    localparam logic [3:0]   DIGIT_MAX       = 4'h9;
    localparam logic [3:0]   DIGIT_RESET     = 4'h0;

    localparam logic [31:0]  CTRL_ADDR       = 32'h0000_0000;
    localparam logic [31:0]  STATUS_ADDR     = 32'h0000_0004;
    localparam int unsigned  CTRL_EN_BIT     = 0;
    localparam logic         CTRL_EN_RESET   = 1'b1;
    localparam int unsigned  STAT_DIGIT_LSB  = 0;
    localparam int unsigned  STAT_NINE_BIT   = 4;
    localparam int unsigned  STAT_ZERO_BIT   = 5;
    localparam logic [1:0]   HTRANS_NONSEQ   = 2'h2;
    localparam logic         HRESP_OKAY      = 1'b0;
endpackage : bcd_pkg

// File: rtl/bcd_digit.sv
// One cascadable decimal up/down counter digit with an AHB-Lite register slave.
`timescale 1ns/100ps

// Overview of operation
// - Hold one decimal digit, count up to 5 MHz.
// - Up or down gate picks counting direction.
// - Both gates and preset gate low: clock pulse changes nothing.
// - Reset, preset gate, one pulse loads bits.
// - Shared clock; advance only if lower digits permit.
// - Digit bits driven directly and isolated copy.
module bcd_digit
    import bcd_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    input  wire logic        i_count_clk,
    input  wire logic        i_count_up,
    input  wire logic        i_count_down,
    input  wire logic        i_digit_reset_n,
    input  wire logic        i_preset_en,
    input  wire logic [3:0]  i_load_bit_input,
    input  wire logic        i_lower_nine,
    input  wire logic        i_lower_zero,
    output logic      [3:0]  o_digit,
    output logic      [3:0]  o_digit_iso,
    output logic             o_nine,
    output logic             o_zero,
    output logic             o_carry,
    output logic             o_borrow,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);

    logic        count_clk_d;
    logic        count_edge;
    logic        step;
    logic        ctrl_en;
    logic        wr_pend;
    logic [31:0] wr_addr;
    logic [3:0]  next_digit;
    logic        next_carry;
    logic        next_borrow;
    logic        addr_ok;

    // The count clock is a plain synchronous input; its rising edge is one step.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            count_clk_d <= 1'b0;
        end else begin
            count_clk_d <= i_count_clk;
        end
    end

    // Edge detect, rate
    // Any count clock up to a quarter of the system clock gives one step per edge.
    assign count_edge = i_count_clk & ~count_clk_d;
    assign step       = count_edge & ctrl_en;

    // Direction gates are sampled in the edge cycle; the controller keeps them
    // steady beforehand, so no extra delay stage is spent here.
    always_comb begin
        next_digit  = o_digit;
        next_carry  = 1'b0;
        next_borrow = 1'b0;
        if (!i_digit_reset_n) begin
            next_digit = DIGIT_RESET;
        end else if (step) begin
            if (i_preset_en && !i_count_up && !i_count_down) begin
                next_digit = i_load_bit_input;
            end else if (i_count_up && !i_count_down) begin
                if (i_lower_nine) begin
                    if (o_digit >= DIGIT_MAX) begin
                        next_digit = DIGIT_MIN;
                        next_carry = 1'b1;
                    end else begin
                        next_digit = o_digit + 4'h1;
                    end
                end
            end else if (i_count_down && !i_count_up) begin
                if (i_lower_zero) begin
                    if (o_digit == DIGIT_MIN) begin
                        next_digit  = DIGIT_MAX;
                        next_borrow = 1'b1;
                    end
                    else begin
                        next_digit = o_digit - 4'h1;
                    end
                end
            end
            // Idle gates hold
            // Both gates low with the preset gate low, or both gates high, leaves the digit as it stands.
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_digit     <= DIGIT_RESET;
            o_digit_iso <= DIGIT_RESET;
            o_nine      <= 1'b0;
            o_zero      <= 1'b1;
        end else begin
            o_digit     <= next_digit;
            o_digit_iso <= next_digit;
            o_nine      <= (next_digit == DIGIT_MAX);
            o_zero      <= (next_digit == DIGIT_MIN);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_carry  <= 1'b0;
            o_borrow <= 1'b0;
        end else begin
            o_carry  <= next_carry;
            o_borrow <= next_borrow;
        end
    end

    // Bus slave: zero wait states, read data registered in the address phase.
    assign addr_ok = hsel & hready & htrans[1];

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            wr_pend <= 1'b0;
            wr_addr <= 32'h0000_0000;
        end else begin
            wr_pend <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_addr <= haddr;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            ctrl_en <= CTRL_EN_RESET;
        end else if (wr_pend && wr_addr == CTRL_ADDR) begin
            ctrl_en <= hwdata[CTRL_EN_BIT];
        end
    end

    // Status reflects the digit as stored at the address phase; a count in that
    // same cycle shows up on the next read.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= 32'h0000_0000;
            if (haddr == CTRL_ADDR) begin
                hrdata[CTRL_EN_BIT] <= ctrl_en;
            end else if (haddr == STATUS_ADDR) begin
                hrdata[STAT_DIGIT_LSB +: 4] <= o_digit;
                hrdata[STAT_NINE_BIT]       <= o_nine;
                hrdata[STAT_ZERO_BIT]       <= o_zero;
            end
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    sequence s_up_step;
        step && i_digit_reset_n && i_count_up && !i_count_down && i_lower_nine && !i_preset_en;
    endsequence

    sequence s_down_step;
        step && i_digit_reset_n && i_count_down && !i_count_up && i_lower_zero && !i_preset_en;
    endsequence

    a_idle_hold: assert property (
        (i_digit_reset_n && (!count_edge || (!i_count_up && !i_count_down && !i_preset_en)))
        |=> $stable(o_digit))
        else $error("Digit changed without a counting step.");

    a_up_count: assert property (
        s_up_step |=> o_digit == (($past(o_digit) == DIGIT_MAX) ? DIGIT_MIN : $past(o_digit) + 4'h1))
        else $error("Up count produced a wrong digit.");

    a_down_count: assert property (
        s_down_step |=> o_digit == (($past(o_digit) == DIGIT_MIN) ? DIGIT_MAX : $past(o_digit) - 4'h1))
        else $error("Down count produced a wrong digit.");

    a_preset_load: assert property (
        (step && i_digit_reset_n && i_preset_en && !i_count_up && !i_count_down)
        |=> o_digit == $past(i_load_bit_input))
        else $error("Preset pulse did not load the bits.");

    a_cascade_inhibit: assert property (
        (i_digit_reset_n && !i_preset_en && i_count_up && !i_count_down && !i_lower_nine)
        |=> $stable(o_digit))
        else $error("Digit advanced while a lower digit inhibits it.");

    a_carry_out: assert property (
        (s_up_step and o_digit == DIGIT_MAX) |=> o_carry ##1 !o_carry || $past(next_carry))
        else $error("Carry missing or stretched after nine.");

    a_borrow_out: assert property (
        o_borrow |-> $past(o_digit) == DIGIT_MIN && o_digit == DIGIT_MAX)
        else $error("Borrow raised without a zero to nine step.");

    a_flag_match: assert property (
        o_nine == (o_digit == DIGIT_MAX) && o_zero == (o_digit == DIGIT_MIN))
        else $error("Nine or zero flag disagrees with the digit.");

    a_iso_copy: assert property (
        o_digit_iso == o_digit)
        else $error("Isolated copy differs from the digit.");

    a_dir_select: assert property (
        (s_up_step and o_digit != DIGIT_MAX) |=> o_digit > $past(o_digit))
        else $error("Up gate did not raise the digit.");

    a_one_edge: assert property (
        (i_count_clk && !i_preset_en && i_digit_reset_n) ##1 i_count_clk |-> !count_edge)
        else $error("A held count clock stepped twice.");

    a_ctrl_gate: assert property (
        (!ctrl_en && i_digit_reset_n) |=> $stable(o_digit))
        else $error("Digit changed while counting is disabled.");

    // The clear pin wins over every gate, so the next edge must show zero.
    a_digit_clear: assert property (
        !i_digit_reset_n |=> o_digit == DIGIT_RESET)
        else $error("Digit clear did not give zero.");

    a_clear_flags: assert property (
        !i_digit_reset_n |=> o_zero && !o_nine && !o_carry && !o_borrow)
        else $error("Flags wrong after a digit clear.");

    a_carry_cause: assert property (
        o_carry |-> $past(o_digit) == DIGIT_MAX && o_digit == DIGIT_MIN)
        else $error("Carry raised without a nine to zero step.");

    // A step needs the count clock low for a cycle first, so pulses never merge.
    a_carry_short: assert property (
        o_carry |=> !o_carry)
        else $error("Carry stood longer than one cycle.");

    a_borrow_short: assert property (
        o_borrow |=> !o_borrow)
        else $error("Borrow stood longer than one cycle.");

    a_down_select: assert property (
        (s_down_step and o_digit != DIGIT_MIN) |=> o_digit < $past(o_digit))
        else $error("Down gate did not lower the digit.");

    a_down_inhibit: assert property (
        (i_digit_reset_n && !i_preset_en && i_count_down && !i_count_up && !i_lower_zero)
        |=> $stable(o_digit))
        else $error("Digit fell while a lower digit inhibits it.");

    // Both gates high is undefined for the controller; this block chooses to hold.
    a_both_gates: assert property (
        (i_digit_reset_n && !i_preset_en && i_count_up && i_count_down)
        |=> $stable(o_digit))
        else $error("Digit changed with both gates high.");

    // The slave never stretches a transfer and never reports an error.
    a_bus_okay: assert property (
        hreadyout && hresp == HRESP_OKAY)
        else $error("Bus slave not ready or not OKAY.");

    a_ctrl_write: assert property (
        (wr_pend && wr_addr == CTRL_ADDR) |=> ctrl_en == $past(hwdata[CTRL_EN_BIT]))
        else $error("Enable write did not land.");

    // Status shows the digit as it stood in the address phase.
    a_status_read: assert property (
        (addr_ok && !hwrite && haddr == STATUS_ADDR)
        |=> hrdata == {26'h0, $past(o_zero), $past(o_nine), $past(o_digit)})
        else $error("Status read returned wrong data.");

endmodule : bcd_digit

// File: verif/bcd_ctl_model.sv
// Controller model that sequences the gate and count clock inputs of one digit.
`timescale 1ns/100ps
module bcd_ctl_model (
    input  wire logic i_clk_sys,
    input  wire logic i_req,
    input  wire logic i_up,
    input  wire logic i_down,
    output logic      o_count_clk,
    output logic      o_count_up,
    output logic      o_count_down,
    output logic      o_busy
);
    logic [2:0] ph = 3'h0;
    logic       up_q = 1'b0;
    logic       dn_q = 1'b0;
    always_ff @(posedge i_clk_sys) begin
        if (i_req) begin
            ph   <= 3'h1;
            up_q <= i_up;
            dn_q <= i_down & ~i_up;
        end else if (ph != 3'h0) begin
            ph <= ph + 3'h1;
        end
    end
    assign o_count_up   = (ph != 3'h0) & up_q;
    assign o_count_down = (ph != 3'h0) & dn_q;
    assign o_count_clk  = (ph == 3'h3) | (ph == 3'h4);
    assign o_busy       = (ph != 3'h0) | i_req;
endmodule // bcd_ctl_model

// File: verif/bcd_updown_counter_digit_tb.sv
// Self-checking bench for one decimal counter digit and its register slave.
`timescale 1ns/100ps
module bcd_updown_counter_digit_tb;
    import bcd_pkg::*;
    logic        clk, rstn, req, mu, md, cclk, up, dn, busy;
    logic        dres_n, pre, lnine, lzero, hsel, hwrite, hrdy;
    logic [3:0]  load, dig, iso;
    logic        nine, zero, carry, borrow, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    int          n_fail, tests_run, n_carry, n_borrow;

    bcd_ctl_model u_bcd_ctl_model (.i_clk_sys(clk), .i_req(req), .i_up(mu), .i_down(md),
        .o_count_clk(cclk), .o_count_up(up), .o_count_down(dn), .o_busy(busy));
    bcd_digit u_bcd_digit (.i_clk_sys(clk), .i_rstn(rstn), .i_count_clk(cclk), .i_count_up(up),
        .i_count_down(dn), .i_digit_reset_n(dres_n), .i_preset_en(pre), .i_load_bit_input(load),
        .i_lower_nine(lnine), .i_lower_zero(lzero), .o_digit(dig), .o_digit_iso(iso), .o_nine(nine),
        .o_zero(zero), .o_carry(carry), .o_borrow(borrow), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
        .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (carry === 1'b1) n_carry++;
        if (borrow === 1'b1) n_borrow++;
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1; htrans <= HTRANS_NONSEQ; haddr <= a; hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
        chk("hresp", HRESP_OKAY, hresp);
    endtask
    task step(input logic u, input logic d);
        @(posedge clk);
        req <= 1'b1; mu <= u; md <= d;
        @(posedge clk);
        req <= 1'b0;
        @(negedge clk);
        for (int k = 0; k < 20 && busy; k++) @(negedge clk);
    endtask
    task t_reset;
        chk("zero", 1, zero);
        ahb(1'b0, STATUS_ADDR, 0);
        chk("status", 32'h20, rd);
        ahb(1'b0, CTRL_ADDR, 0);
        chk("ctrl", 32'h1, rd);
    endtask
    task t_up;
        for (int i = 1; i <= 10; i++) begin
            step(1'b1, 1'b0);
            chk("up digit", i % 10, dig);
            chk("nine", i == 9, nine);
        end
        chk("carries", 1, n_carry);
    endtask
    task t_down;
        step(1'b0, 1'b1);
        chk("down digit", 9, dig);
        chk("borrows", 1, n_borrow);
        step(1'b0, 1'b0);
        chk("hold digit", 9, dig);
        @(posedge clk);
        lnine <= 1'b0;
        step(1'b1, 1'b0);
        chk("inhibit", 9, dig);
        @(posedge clk);
        lnine <= 1'b1;
    endtask
    task t_preset;
        @(posedge clk);
        dres_n <= 1'b0;
        @(posedge clk);
        dres_n <= 1'b0;
        pre <= 1'b1; load <= 4'h7;
        @(posedge clk);
        chk("clear", 0, dig);
        dres_n <= 1'b1;
        step(1'b0, 1'b0);
        chk("preset", 7, dig);
        chk("iso", 7, iso);
        @(posedge clk);
        pre <= 1'b0;
    endtask
    task t_bus;
        ahb(1'b1, CTRL_ADDR, 0);
        step(1'b1, 1'b0);
        chk("disabled", 7, dig);
        ahb(1'b1, CTRL_ADDR, 1);
        step(1'b1, 1'b0);
        ahb(1'b0, 32'h10, 0);
        chk("unmapped", 0, rd);
        ahb(1'b0, STATUS_ADDR, 0);
        chk("status", 32'h8, rd);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        n_fail = 0; tests_run = 0; n_carry = 0; n_borrow = 0;
        rstn = 1'b0; req = 1'b0; mu = 1'b0; md = 1'b0; dres_n = 1'b1; pre = 1'b0;
        lnine = 1'b1; lzero = 1'b1;
        load = 4'h0; hsel = 1'b0; hwrite = 1'b0;
        htrans = 2'h0; haddr = 32'h0; hwdata = 32'h0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_up;
        t_down;
        t_preset;
        t_bus;
        wrap_up;
    end
    initial begin
        #200000;
        n_fail++;
        wrap_up;
    end
endmodule // bcd_updown_counter_digit_tb
